// *** bms_word_sum.sv ***
`timescale 1ns/100ps
package bms_pkg;
	// clock and timing
	localparam int unsigned CLK_MHZ          = 100;
	localparam int unsigned SAMPLE_TIME_US   = 3000;
	localparam int unsigned ERASE_TIME_MS    = 100;
	localparam int unsigned PROGRAM_TIME_MS  = 1;
	localparam int unsigned SAMPLE_CYCLES    = SAMPLE_TIME_US * CLK_MHZ;
	localparam int unsigned ERASE_CYCLES     = ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned PROGRAM_CYCLES   = PROGRAM_TIME_MS * 1000 * CLK_MHZ;
	// flash layout
	localparam int unsigned BLOCK_BYTES      = 256;
	localparam int unsigned VECTOR_WORDS     = 8;
	localparam logic [31:0] VECTOR_BASE      = 32'h0000_0000;
	localparam logic [31:0] CHECK_WORD_ADDR  = 32'h0000_001c;
	localparam logic [31:0] NO_SAMPLE_ADDR   = 32'h0000_02fc;
	// reset values
	localparam logic        PIN_RESET_LEVEL  = 1'b1;

	// final boot decision, one bit per outcome
	typedef struct packed {
		logic run_user;
		logic usb_msc;
		logic uart_isp;
		logic autobaud;
	} bms_boot_t;

	// flash word read request
	typedef struct packed {
		logic        req;
		logic [31:0] addr;
	} bms_rd_t;
endpackage

module bms_word_sum
	import bms_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        start_i,
	input  wire logic [31:0] base_i,
	input  wire logic [3:0]  count_i,
	input  wire logic [31:0] rd_data_i,
	input  wire logic        rd_valid_i,
	output bms_rd_t          rd_o,
	output logic      [31:0] sum_o,
	output logic             done_o
);
	bms_rd_t     rd_reg,   rd_next;
	logic [31:0] sum_reg,  sum_next;
	logic [3:0]  idx_reg,  idx_next;
	logic        done_reg, done_next;

	// walk count_i words from base_i, adding each into the sum
	always_comb begin
		rd_next   = rd_reg;
		sum_next  = sum_reg;
		idx_next  = idx_reg;
		done_next = 1'b0;
		if (start_i && !rd_reg.req) begin
			rd_next.req  = 1'b1;
			rd_next.addr = base_i;
			sum_next     = 32'h0000_0000;
			idx_next     = 4'h0;
		end else if (rd_reg.req && rd_valid_i) begin
			sum_next = sum_reg + rd_data_i;
			idx_next = idx_reg + 4'h1;
			rd_next.addr = rd_reg.addr + 32'h0000_0004;
			if (idx_reg == count_i - 4'h1) begin
				rd_next.req = 1'b0;
				done_next   = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_reg   <= '0;
			sum_reg  <= 32'h0000_0000;
			idx_reg  <= 4'h0;
			done_reg <= 1'b0;
		end else begin
			rd_reg   <= rd_next;
			sum_reg  <= sum_next;
			idx_reg  <= idx_next;
			done_reg <= done_next;
		end
	end

	assign rd_o   = rd_reg;
	assign sum_o  = sum_reg;
	assign done_o = done_reg;
endmodule

// *** boot_mode_selector.sv ***
`timescale 1ns/100ps
module boot_mode_selector
	import bms_pkg::*;
#(
	parameter bit          HAS_USB         = 1'b1,
	parameter int unsigned SAMPLE_CNT      = SAMPLE_CYCLES,
	parameter int unsigned ERASE_CNT       = ERASE_CYCLES,
	parameter int unsigned PROGRAM_CNT     = PROGRAM_CYCLES,
	parameter logic [31:0] NO_SAMPLE_VALUE = 32'h5a5a_a5a5 // arbitrary value
)
(
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        program_request_pin_i,
	input  wire logic        interface_select_pin_i,
	input  wire logic        wdt_overflow_i,
	input  wire logic [31:0] rd_data_i,
	input  wire logic        rd_valid_i,
	input  wire logic        erase_start_i,
	input  wire logic        program_start_i,
	output bms_rd_t          rd_o,
	output logic             boot_done_o,
	output bms_boot_t        boot_o,
	output logic             flash_busy_o,
	output logic             flash_done_o
);
	localparam int SW = $clog2(SAMPLE_CNT + 1);
	localparam int FW = $clog2(ERASE_CNT + PROGRAM_CNT + 1);

	typedef enum logic [2:0] {
		ST_CFG, ST_CFG_WAIT, ST_DELAY, ST_DECIDE, ST_SUM, ST_SUM_WAIT, ST_DONE
	} bms_state_t;

	logic        rst_s1_reg, rst_s2_reg;
	logic        rst_n;
	logic [1:0]  req_sync_reg, sel_sync_reg, wdt_sync_reg;
	bms_state_t  state_reg,    state_next;
	logic [SW-1:0] dly_reg,    dly_next;
	logic        nosamp_reg,   nosamp_next;
	logic        start_reg,    start_next;
	logic        isp_reg,      isp_next;
	logic        samp_wdt_reg, samp_wdt_next;
	logic        sel_reg,      sel_next;
	logic        done_reg,     done_next;
	bms_boot_t   boot_reg,     boot_next;
	logic [FW-1:0] fcnt_reg,   fcnt_next;
	logic        busy_reg,     busy_next;
	logic        fdone_reg,    fdone_next;
	logic [31:0] ws_base;
	logic [3:0]  ws_count;
	logic [31:0] ws_sum;
	logic        ws_done;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	// pin synchronisers, only the second stage is read
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			req_sync_reg <= {2{PIN_RESET_LEVEL}};
			sel_sync_reg <= 2'h0;
			wdt_sync_reg <= 2'h0;
		end else begin
			req_sync_reg <= {req_sync_reg[0], program_request_pin_i};
			sel_sync_reg <= {sel_sync_reg[0], interface_select_pin_i};
			wdt_sync_reg <= {wdt_sync_reg[0], wdt_overflow_i};
		end
	end

	// shared flash word reader: config word first, then vector table
	assign ws_base  = (state_reg == ST_CFG || state_reg == ST_CFG_WAIT)
	                ? NO_SAMPLE_ADDR : VECTOR_BASE;
	assign ws_count = (state_reg == ST_CFG || state_reg == ST_CFG_WAIT)
	                ? 4'h1 : 4'(VECTOR_WORDS);

	bms_word_sum u_sum (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n),
		.start_i    (start_reg),
		.base_i     (ws_base),
		.count_i    (ws_count),
		.rd_data_i  (rd_data_i),
		.rd_valid_i (rd_valid_i),
		.rd_o       (rd_o),
		.sum_o      (ws_sum),
		.done_o     (ws_done)
	);

	// boot sequencer
	always_comb begin
		state_next    = state_reg;
		dly_next      = dly_reg;
		nosamp_next   = nosamp_reg;
		start_next    = 1'b0;
		isp_next      = isp_reg;
		samp_wdt_next = samp_wdt_reg;
		sel_next      = sel_reg;
		done_next     = done_reg;
		boot_next     = boot_reg;
		unique case (state_reg)
			ST_CFG: begin
				start_next = 1'b1;
				state_next = ST_CFG_WAIT;
			end
			ST_CFG_WAIT: begin
				if (ws_done) begin
					nosamp_next = (ws_sum == NO_SAMPLE_VALUE);
					state_next  = ST_DELAY;
				end
			end
			ST_DELAY: begin
				// wait out the window the host holds the pins for
				dly_next = dly_reg + SW'(1);
				if (dly_reg == SW'(SAMPLE_CNT - 1))
					state_next = ST_DECIDE;
			end
			ST_DECIDE: begin
				// single sample of both pins per reset
				samp_wdt_next = wdt_sync_reg[1];
				sel_next      = HAS_USB && sel_sync_reg[1];
				isp_next      = !nosamp_reg && !req_sync_reg[1]
				              && !wdt_sync_reg[1];
				if (isp_next) begin
					boot_next.usb_msc  = sel_next;
					boot_next.uart_isp = !sel_next;
					done_next          = 1'b1;
					state_next         = ST_DONE;
				end else begin
					state_next = ST_SUM;
				end
			end
			ST_SUM: begin
				start_next = 1'b1;
				state_next = ST_SUM_WAIT;
			end
			ST_SUM_WAIT: begin
				if (ws_done) begin
					if (ws_sum == 32'h0000_0000) begin
						boot_next.run_user = 1'b1;
					end else if (sel_reg) begin
						boot_next.usb_msc = 1'b1;
					end else begin
						boot_next.autobaud = 1'b1;
					end
					done_next  = 1'b1;
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				state_next = ST_DONE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= ST_CFG;
			dly_reg      <= '0;
			nosamp_reg   <= 1'b0;
			start_reg    <= 1'b0;
			isp_reg      <= 1'b0;
			samp_wdt_reg <= 1'b0;
			sel_reg      <= 1'b0;
			done_reg     <= 1'b0;
			boot_reg     <= '0;
		end else begin
			state_reg    <= state_next;
			dly_reg      <= dly_next;
			nosamp_reg   <= nosamp_next;
			start_reg    <= start_next;
			isp_reg      <= isp_next;
			samp_wdt_reg <= samp_wdt_next;
			sel_reg      <= sel_next;
			done_reg     <= done_next;
			boot_reg     <= boot_next;
		end
	end

	// flash operation timer; starts while busy are ignored, erase wins
	always_comb begin
		fcnt_next  = fcnt_reg;
		busy_next  = busy_reg;
		fdone_next = 1'b0;
		if (!busy_reg && erase_start_i) begin
			busy_next = 1'b1;
			fcnt_next = FW'(ERASE_CNT - 1);
		end else if (!busy_reg && program_start_i) begin
			busy_next = 1'b1;
			fcnt_next = FW'(PROGRAM_CNT - 1);
		end else if (busy_reg) begin
			if (fcnt_reg == '0) begin
				busy_next  = 1'b0;
				fdone_next = 1'b1;
			end else begin
				fcnt_next = fcnt_reg - FW'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fcnt_reg  <= '0;
			busy_reg  <= 1'b0;
			fdone_reg <= 1'b0;
		end else begin
			fcnt_reg  <= fcnt_next;
			busy_reg  <= busy_next;
			fdone_reg <= fdone_next;
		end
	end

	assign boot_done_o  = done_reg;
	assign boot_o       = boot_reg;
	assign flash_busy_o = busy_reg;
	assign flash_done_o = fdone_reg;

	// helper: length of each busy period and the kind that started it
	logic [FW-1:0] blen_reg;
	logic          berase_reg;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			blen_reg   <= '0;
			berase_reg <= 1'b0;
		end else begin
			blen_reg   <= busy_reg ? blen_reg + FW'(1) : '0;
			if (!busy_reg)
				berase_reg <= erase_start_i;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	a_no_early_boot: assert property (
		!done_reg |-> boot_reg == '0)
		else $error("boot outcome shown before decision");
	a_one_outcome: assert property (
		done_reg |-> $onehot(boot_reg))
		else $error("boot outcome not exactly one");
	a_decision_hold: assert property (
		done_reg |=> done_reg && $stable(boot_reg))
		else $error("boot decision changed");
	a_request_isp: assert property (
		state_reg == ST_DECIDE && !req_sync_reg[1] && !wdt_sync_reg[1]
		&& !nosamp_reg |=> done_reg && (boot_reg.usb_msc || boot_reg.uart_isp))
		else $error("request did not enter programming at once");
	a_usb_select: assert property (
		$rose(done_reg) && isp_reg && sel_reg |-> boot_reg.usb_msc)
		else $error("usb programming not chosen");
	a_uart_select: assert property (
		$rose(done_reg) && isp_reg && !sel_reg |-> boot_reg.uart_isp)
		else $error("uart programming not chosen");
	a_no_usb_part: assert property (
		!HAS_USB |-> !boot_reg.usb_msc)
		else $error("usb chosen on part without usb");
	a_wdt_ignores: assert property (
		samp_wdt_reg |-> !isp_reg)
		else $error("request honoured after watchdog overflow");
	a_nosample: assert property (
		nosamp_reg |-> !isp_reg)
		else $error("request sampled though disabled");
	a_sample_delay: assert property (
		$rose(state_reg == ST_DECIDE) |-> dly_reg == SW'(SAMPLE_CNT))
		else $error("pins sampled at wrong time");
	a_user_valid: assert property (
		state_reg == ST_SUM_WAIT && ws_done |=>
		boot_reg.run_user == (ws_sum == 32'h0000_0000))
		else $error("user code validity misjudged");
	a_erase_time: assert property (
		$fell(busy_reg) && berase_reg |-> blen_reg == FW'(ERASE_CNT))
		else $error("erase time wrong");
	a_prog_time: assert property (
		$fell(busy_reg) && !berase_reg |-> blen_reg == FW'(PROGRAM_CNT))
		else $error("program time wrong");

	c_user: cover property ($rose(done_reg) && boot_reg.run_user);
	c_uart: cover property ($rose(done_reg) && boot_reg.uart_isp);
	c_usb: cover property ($rose(done_reg) && boot_reg.usb_msc);
	c_autobaud: cover property ($rose(done_reg) && boot_reg.autobaud);
endmodule

// *** bms_host_model.sv ***
`timescale 1ns/100ps
module bms_host_model
	import bms_pkg::*;
(
	input  wire logic         clk_i,
	input  wire bms_rd_t      rd_i,
	input  wire logic         slow_i,
	input  wire logic [31:0]  cfg_i,
	input  wire logic [255:0] vec_i,
	input  wire logic         sync_i,
	output logic      [31:0]  rd_data_o,
	output logic              rd_valid_o,
	output logic              tx_o
);
	localparam int BIT_CYC = 4;
	logic       skip_reg;
	logic [9:0] frame_reg;
	int         bit_cnt;
	logic       sync_seen;

	initial begin
		rd_valid_o = 1'b0;
		rd_data_o  = 32'h0000_0000;
		skip_reg   = 1'b0;
		tx_o       = 1'b1;
		frame_reg  = '1;
		bit_cnt    = 0;
		sync_seen  = 1'b0;
	end

	// one question mark frame, 8 data no parity 1 stop, when baud search starts
	always @(posedge clk_i) begin
		#1;
		if (sync_i && !sync_seen) begin
			frame_reg = {1'b1, 8'h3f, 1'b0};
			bit_cnt   = 10 * BIT_CYC;
		end
		sync_seen = sync_i;
		if (bit_cnt > 0) begin
			tx_o = frame_reg[0];
			bit_cnt--;
			if (bit_cnt % BIT_CYC == 0)
				frame_reg = {1'b1, frame_reg[9:1]};
		end else begin
			tx_o = 1'b1; // idle high, waiting for the answer
		end
	end

	// answer a pending read just after each edge, every other cycle if slow
	always @(posedge clk_i) begin
		#1;
		skip_reg = slow_i & ~skip_reg;
		if (rd_i.req && !skip_reg) begin
			rd_valid_o = 1'b1;
			if (rd_i.addr == NO_SAMPLE_ADDR)
				rd_data_o = cfg_i;
			else if (rd_i.addr[31:5] == 27'h0)
				rd_data_o = vec_i[32*rd_i.addr[4:2] +: 32];
			else
				rd_data_o = ~cfg_i; // unmapped place gives junk
		end else begin
			rd_valid_o = 1'b0;
			rd_data_o  = ~rd_data_o; // word inverted on every idle cycle, so the last word returns every other cycle
		end
	end
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
	import bms_pkg::*;
	localparam logic [31:0] NOSAMP = 32'h5a5a_a5a5; // arbitrary value
	localparam int          SCNT   = 20;
	localparam int          ECNT   = 50;
	localparam int          PCNT   = 10;
	logic         tx;
	logic [7:0]   rx;
	logic         clk_i = 1'b0;
	logic         resetn_i = 1'b0;
	logic         req_pin = 1'b1;
	logic         sel_pin = 1'b0;
	logic         wdt = 1'b0;
	logic         slow = 1'b0;
	logic         erase = 1'b0;
	logic         prog = 1'b0;
	logic [31:0]  cfg = 32'h0;
	logic [255:0] vec = '0;
	logic [31:0]  seed = 32'd30559;
	int           n_mismatch = 0;
	int           comparisons = 0;
	bms_rd_t      rd_a, rd_b;
	logic [31:0]  dat_a, dat_b;
	logic         val_a, val_b, done_a, done_b, busy, fdone;
	bms_boot_t    boot_a, boot_b;

	// free running clock
	always #5 clk_i = ~clk_i;

	boot_mode_selector #(.SAMPLE_CNT(SCNT), .ERASE_CNT(ECNT),
		.PROGRAM_CNT(PCNT), .NO_SAMPLE_VALUE(NOSAMP)) u_boot_mode_selector (
		.clk_i(clk_i), .resetn_i(resetn_i),
		.program_request_pin_i(req_pin), .interface_select_pin_i(sel_pin),
		.wdt_overflow_i(wdt), .rd_data_i(dat_a), .rd_valid_i(val_a),
		.erase_start_i(erase), .program_start_i(prog), .rd_o(rd_a),
		.boot_done_o(done_a), .boot_o(boot_a), .flash_busy_o(busy),
		.flash_done_o(fdone));
	boot_mode_selector #(.HAS_USB(1'b0), .SAMPLE_CNT(SCNT), .ERASE_CNT(ECNT),
		.PROGRAM_CNT(PCNT), .NO_SAMPLE_VALUE(NOSAMP)) u_boot_mode_selector_b (
		.clk_i(clk_i), .resetn_i(resetn_i),
		.program_request_pin_i(req_pin), .interface_select_pin_i(sel_pin),
		.wdt_overflow_i(wdt), .rd_data_i(dat_b), .rd_valid_i(val_b),
		.erase_start_i(erase), .program_start_i(prog), .rd_o(rd_b),
		.boot_done_o(done_b), .boot_o(boot_b), .flash_busy_o(),
		.flash_done_o());
	bms_host_model u_bms_host_model (.clk_i(clk_i), .rd_i(rd_a),
		.slow_i(slow), .cfg_i(cfg), .vec_i(vec),
		.sync_i(boot_a.autobaud), .rd_data_o(dat_a),
		.rd_valid_o(val_a), .tx_o(tx));
	bms_host_model u_bms_host_model_b (.clk_i(clk_i), .rd_i(rd_b),
		.slow_i(slow), .cfg_i(cfg), .vec_i(vec),
		.sync_i(boot_b.autobaud), .rd_data_o(dat_b),
		.rd_valid_o(val_b), .tx_o());

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected decision from pins, flags and code validity
	function automatic bms_boot_t exp_boot(input logic usb, rq, sl, wd, ns,
		ok);
		bms_boot_t e;
		e = '0;
		if (!rq && !wd && !ns) begin
			if (usb && sl) e.usb_msc = 1'b1;
			else e.uart_isp = 1'b1;
		end else if (ok) e.run_user = 1'b1;
		else if (usb && sl) e.usb_msc = 1'b1;
		else e.autobaud = 1'b1;
		return e;
	endfunction

	task automatic check(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// host sync frame as seen on the line, sampled mid-bit
	always @(negedge tx) begin
		repeat (6) @(posedge clk_i);
		for (int j = 0; j < 8; j++) begin
			rx[j] = tx;
			repeat (4) @(posedge clk_i);
		end
		check({24'h0, rx}, 32'h3f);
	end

	// one boot per case: k = {code ok, no sample, wdt, select, request}
	task automatic boot_case(input logic [4:0] k);
		logic [31:0] s;
		logic [31:0] r;
		int          i;
		bms_boot_t   ea, eb;
		s = 32'h0;
		ea = exp_boot(1'b1, k[0], k[1], k[2], k[3], k[4]);
		eb = exp_boot(1'b0, k[0], k[1], k[2], k[3], k[4]);
		for (i = 0; i < 7; i++) begin
			vec[32*i +: 32] = xs();
			s = s + vec[32*i +: 32];
		end
		vec[224 +: 32] = k[4] ? -s : 32'h1 - s;
		r = xs();
		cfg = k[3] ? NOSAMP : {r[31:1], ~NOSAMP[0]};
		slow = r[0];
		req_pin = k[0];
		sel_pin = k[1];
		wdt = k[2];
		@(posedge clk_i);
		#1 resetn_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1 check(32'(boot_a), 32'h0);
		for (i = 0; i < 300 && !(done_a === 1'b1 && done_b === 1'b1); i++)
			@(posedge clk_i);
		#1 check(32'(boot_a), 32'(ea));
		check(32'(boot_b), 32'(eb));
		req_pin = ~req_pin;
		sel_pin = ~sel_pin;
		wdt = ~wdt;
		repeat (30) @(posedge clk_i);
		#1 check(32'(boot_a), 32'(ea));
		check({31'h0, done_b}, 32'h1);
	endtask

	// timed flash operation with a refused start while busy
	task automatic flash_op(input logic e, p, input int n);
		int c;
		@(posedge clk_i);
		#1 erase = e;
		prog = p;
		@(posedge clk_i);
		#1 erase = 1'b0;
		c = 0;
		while (busy === 1'b1 && c < 20000) begin
			prog = (c == 3);
			@(posedge clk_i);
			#1 c++;
		end
		prog = 1'b0;
		check(c, n);
		check({31'h0, fdone}, 32'h1);
		@(posedge clk_i);
		#1 check({30'h0, fdone, busy}, 32'h0);
	endtask

	// main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		for (int k = 0; k < 32; k++)
			boot_case(5'(k));
		flash_op(1'b1, 1'b0, ECNT);
		flash_op(1'b0, 1'b1, PCNT);
		flash_op(1'b1, 1'b1, ECNT);
		close_out();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		close_out();
	end
endmodule
